// ===== smsp_consts.svh
`ifndef SMSP_CONSTS_SVH
`define SMSP_CONSTS_SVH
// Notes on behaviour
// RQ1: 16-bit shifter exchanges 8 or 16 bits
// RQ2: completion sets done flag, irq if enabled
// RQ3: finished word moves into receive buffer
// RQ4: full receive buffer: overflow, new word lost
// RQ5: overflow set: serial clock edges ignored
// RQ6: transmit double-buffered, reload after each word
// RQ7: one buffer: write transmits, read receives
// RQ8: master drives clock pin, slave receives it
// RQ9: master starts as soon as data written
// RQ10: master done mid last bit, slave on latch
// RQ11: slave select gates slave and output pin
// RQ12: select rising resets counters, restart at msb
// RQ13: master clock is system/4 then two prescalers
// RQ14: edge bit picks which edge changes data
// RQ15: polarity bit picks idle clock level
// RQ16: size bit picks 16 or 8 bit words
// RQ17: size change resets the port
// RQ18: out from bit 7 or 15, in at 0
// RQ19: output disable releases serial output pin
// RQ20: framed mode, frame pin direction selectable
// RQ21: frame pulse one clock high, data after
// RQ22: sleep aborts transfer, keeps registers
// RQ23: stop-in-idle halts port during idle
// RQ24: overflow stays until cleared, then resumes
`define SMSP_DW         16
`define SMSP_BYTE_N     5'd8
`define SMSP_WORD_N     5'd16
`define SMSP_LOW_MASK   16'h00ff
`define SMSP_FULL_MASK  16'hffff
`define SMSP_MSB8       7
`define SMSP_MSB16      15
`define SMSP_BASE_HALF  2
`define SMSP_FIFO_DEPTH 16
`define SMSP_FIFO_AW    4
`endif

// ===== smsp_pkg.sv
`include "smsp_consts.svh"
package smsp_pkg;
  typedef enum logic [1:0] {SMSP_IDLE, SMSP_RUN, SMSP_LAST} smsp_ms_e;

  // half period of master clock in system cycles
  function automatic logic [10:0] smsp_half(input logic [1:0] pp, input logic [2:0] sp);
    logic [6:0] p;
    p = (pp == 2'h0) ? 7'h40 : (pp == 2'h1) ? 7'h10 : (pp == 2'h2) ? 7'h04 : 7'h01;
    return 11'(`SMSP_BASE_HALF * p * (4'h8 - {1'b0, sp}));
  endfunction : smsp_half

  // bit presented on the serial output
  function automatic logic smsp_msb(input logic [15:0] sr, input logic ws);
    return ws ? sr[`SMSP_MSB16] : sr[`SMSP_MSB8];
  endfunction : smsp_msb
endpackage : smsp_pkg

// ===== smsp_port.sv
`include "smsp_consts.svh"
module smsp_fifo #(
  parameter int W  = `SMSP_DW,
  parameter int D  = `SMSP_FIFO_DEPTH,
  parameter int AW = `SMSP_FIFO_AW
) (
  input  wire logic         clk,       // system clock
  input  wire logic         reset_n,   // sync reset
  input  wire logic         clk_en,    // freeze when low
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // room left
  input  wire logic [W-1:0] in_data,   // write word
  output logic              out_valid, // word waiting
  input  wire logic         out_ready, // drain accepts
  output logic      [W-1:0] out_data   // oldest word
);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  // handshake and read port
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid & in_ready & clk_en;
  assign pop       = out_valid & out_ready & clk_en;

  // pointer and count update
  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule : smsp_fifo

module smsp_port
  import smsp_pkg::*;
(
  input  wire logic        clk,                   // 10 MHz system clock
  input  wire logic        reset_n,               // sync reset
  input  wire logic        clk_en,                // freeze when low
  input  wire logic        port_enable,           // module on
  input  wire logic        master_mode,           // 1 master, 0 slave
  input  wire logic        word_size_select,      // 1 16-bit, 0 8-bit
  input  wire logic        clock_polarity,        // idle clock level
  input  wire logic        clock_edge_select,     // 1 change on active-to-idle
  input  wire logic        serial_out_disable,    // release output pin
  input  wire logic        framed_mode_enable,    // select pin is frame pulse
  input  wire logic        frame_sync_direction,  // 1 frame input, 0 output
  input  wire logic        slave_select_enable,   // select pin gates slave
  input  wire logic [1:0]  primary_prescale,      // 64/16/4/1
  input  wire logic [2:0]  secondary_prescale,    // 8..1
  input  wire logic        stop_in_idle,          // halt during cpu idle
  input  wire logic        cpu_idle,              // cpu idle state
  input  wire logic        cpu_sleep,             // cpu sleep state
  input  wire logic        tx_valid,              // data buffer write
  output logic             tx_ready,              // write accepted
  input  wire logic [15:0] tx_data,               // write word
  input  wire logic        rx_rd,                 // data buffer read pulse
  output logic      [15:0] rx_data,               // receive buffer
  output logic             rx_full,               // unread word present
  output logic             receive_overflow_flag, // word lost
  input  wire logic        ovf_clear,             // clear overflow pulse
  output logic             port1_done_flag,       // transfer complete
  input  wire logic        done_clear,            // clear done pulse
  input  wire logic        port1_done_irq_enable, // done irq gate
  output logic             done_irq,              // done request
  input  wire logic        serial_clock_pin_in,   // clock pin level
  output logic             serial_clock_pin_out,  // clock pin drive
  output logic             serial_clock_pin_oe,   // clock pin enable
  input  wire logic        serial_in_pin,         // data in pin
  output logic             serial_out_pin,        // data out pin
  output logic             serial_out_pin_oe,     // data out enable
  input  wire logic        slave_select_pin_in,   // select or frame in
  output logic             slave_select_pin_out,  // frame pulse out
  output logic             slave_select_pin_oe    // frame pin enable
);
  logic        sck_m, sck_s, sck_d, sdi_m, sdi_s, ss_m, ss_s, ss_d;
  logic [15:0] serial_shift_reg_r, sr_nxt;
  logic [15:0] receive_holding_buffer_r, rxb_nxt;
  logic [15:0] transmit_holding_buffer_r, txb_nxt;
  logic [15:0] fifo_data, rx_word;
  logic [10:0] div_r, div_nxt, half;
  logic [4:0]  bit_cnt_r, bit_nxt, nbits;
  smsp_ms_e    ms_r, ms_nxt;
  logic        act_r, act_nxt, out_r, out_nxt, fs_r, fs_nxt, armed_r, armed_nxt;
  logic        hold_v_r, hold_v_nxt, loaded_r, loaded_nxt, full_r, full_nxt;
  logic        ovf_r, ovf_nxt, done_r, done_nxt, size_d_r;
  logic        fifo_v, active, size_chg, ss_gate, soft_rst, gen_edge, sck_chg;
  logic        lead, trail, ok, samp, chg, done, load, fs_fall, fr_in, fr_out;

  // transmit fifo feeding the holding buffer
  smsp_fifo #(.W(`SMSP_DW), .D(`SMSP_FIFO_DEPTH), .AW(`SMSP_FIFO_AW)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_v),
    .out_ready (~hold_v_r),
    .out_data  (fifo_data)
  );

  // pin synchronisers, third stage for edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {sck_m, sck_s, sck_d} <= 3'h0;
      {sdi_m, sdi_s}        <= 2'h0;
      {ss_m, ss_s, ss_d}    <= 3'h7;
    end else if (clk_en) begin
      {sck_m, sck_s, sck_d} <= {serial_clock_pin_in, sck_m, sck_s};
      {sdi_m, sdi_s}        <= {serial_in_pin, sdi_m};
      {ss_m, ss_s, ss_d}    <= {slave_select_pin_in, ss_m, ss_s};
    end
  end

  // shared decode of mode, edges and events
  always_comb begin
    active   = port_enable & ~cpu_sleep & ~(cpu_idle & stop_in_idle); // RQ22 RQ23
    size_chg = word_size_select != size_d_r; // RQ17
    ss_gate  = ~master_mode & slave_select_enable & ~framed_mode_enable & ss_s; // RQ11
    soft_rst = ~active | size_chg | ss_gate; // RQ12
    nbits    = word_size_select ? `SMSP_WORD_N : `SMSP_BYTE_N; // RQ16
    half     = smsp_half(primary_prescale, secondary_prescale); // RQ13
    gen_edge = (ms_r != SMSP_IDLE) & (div_r == half - 11'h1);
    sck_chg  = sck_s ^ sck_d;
    fr_in    = framed_mode_enable & frame_sync_direction; // RQ20
    fr_out   = framed_mode_enable & ~frame_sync_direction;
    fs_fall  = ss_d & ~ss_s;
    lead     = master_mode ? gen_edge & ~act_r : sck_chg & (sck_s ^ clock_polarity); // RQ8
    trail    = master_mode ? gen_edge & act_r : sck_chg & ~(sck_s ^ clock_polarity);
    ok       = (~framed_mode_enable | armed_r) & ~ovf_r & ~soft_rst; // RQ5 RQ21
    samp     = ok & (clock_edge_select ? lead : trail); // RQ14
    chg      = ok & (clock_edge_select ? trail : lead);
    done     = samp & (bit_cnt_r == nbits - 5'h1); // RQ1 RQ10
    rx_word  = {serial_shift_reg_r[14:0], sdi_s}
             & (word_size_select ? `SMSP_FULL_MASK : `SMSP_LOW_MASK);
    load     = ~soft_rst & ~ovf_r & ~loaded_r & hold_v_r & (bit_cnt_r == 5'h0)
             & (ms_r == SMSP_IDLE); // RQ6
  end

  // next state of the transfer engine and buffers
  always_comb begin
    ms_nxt     = ms_r;
    div_nxt    = div_r;
    act_nxt    = act_r;
    bit_nxt    = bit_cnt_r;
    sr_nxt     = serial_shift_reg_r;
    out_nxt    = out_r;
    loaded_nxt = loaded_r;
    fs_nxt     = fs_r;
    armed_nxt  = armed_r;
    txb_nxt    = transmit_holding_buffer_r;
    hold_v_nxt = hold_v_r;
    rxb_nxt    = receive_holding_buffer_r;
    full_nxt   = full_r & ~rx_rd; // RQ7
    ovf_nxt    = ovf_r & ~ovf_clear; // RQ24
    done_nxt   = done_r & ~done_clear;
    if (~hold_v_r & fifo_v) begin
      txb_nxt    = fifo_data;
      hold_v_nxt = 1'b1;
    end
    // master clock generator
    if (ms_r != SMSP_IDLE) begin
      div_nxt = gen_edge ? 11'h0 : div_r + 11'h1;
      act_nxt = act_r ^ gen_edge;
    end
    if (load) begin
      sr_nxt     = transmit_holding_buffer_r; // RQ6
      out_nxt    = smsp_msb(transmit_holding_buffer_r, word_size_select); // RQ18
      loaded_nxt = 1'b1;
      hold_v_nxt = 1'b0;
      if (master_mode) begin
        ms_nxt = SMSP_RUN; // RQ9
      end
    end
    if (samp) begin
      sr_nxt  = {serial_shift_reg_r[14:0], sdi_s}; // RQ1 RQ18
      bit_nxt = bit_cnt_r + 5'h1;
    end
    if (chg) begin
      out_nxt = smsp_msb(serial_shift_reg_r, word_size_select); // RQ18
    end
    if (ms_r == SMSP_LAST && gen_edge) begin
      ms_nxt = SMSP_IDLE;
    end
    // frame pulse generate or receive
    if (fr_out & ~armed_r & lead & (loaded_r | load)) begin
      fs_nxt = ~fs_r; // RQ21
      armed_nxt = fs_r;
    end
    if (fr_in & fs_fall) begin
      armed_nxt = 1'b1; // RQ21
    end
    if (done) begin
      bit_nxt    = 5'h0;
      loaded_nxt = 1'b0;
      armed_nxt  = 1'b0;
      done_nxt   = 1'b1; // RQ2
      if (master_mode) begin
        ms_nxt = lead ? SMSP_LAST : SMSP_IDLE; // RQ10
      end
      if (full_r & ~rx_rd) begin
        ovf_nxt = 1'b1; // RQ4
      end else begin
        rxb_nxt  = rx_word; // RQ3
        full_nxt = 1'b1;
      end
    end
    if (soft_rst) begin
      ms_nxt     = SMSP_IDLE; // RQ12 RQ17 RQ22
      div_nxt    = 11'h0;
      act_nxt    = 1'b0;
      bit_nxt    = 5'h0;
      loaded_nxt = 1'b0;
      fs_nxt     = 1'b0;
      armed_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ms_r                      <= SMSP_IDLE;
      div_r                     <= 11'h0;
      act_r                     <= 1'b0;
      bit_cnt_r                 <= 5'h0;
      serial_shift_reg_r        <= 16'h0000;
      out_r                     <= 1'b0;
      loaded_r                  <= 1'b0;
      fs_r                      <= 1'b0;
      armed_r                   <= 1'b0;
      transmit_holding_buffer_r <= 16'h0000;
      hold_v_r                  <= 1'b0;
      receive_holding_buffer_r  <= 16'h0000;
      full_r                    <= 1'b0;
      ovf_r                     <= 1'b0;
      done_r                    <= 1'b0;
      size_d_r                  <= 1'b0;
    end else if (clk_en) begin
      ms_r                      <= ms_nxt;
      div_r                     <= div_nxt;
      act_r                     <= act_nxt;
      bit_cnt_r                 <= bit_nxt;
      serial_shift_reg_r        <= sr_nxt;
      out_r                     <= out_nxt;
      loaded_r                  <= loaded_nxt;
      fs_r                      <= fs_nxt;
      armed_r                   <= armed_nxt;
      transmit_holding_buffer_r <= txb_nxt;
      hold_v_r                  <= hold_v_nxt;
      receive_holding_buffer_r  <= rxb_nxt;
      full_r                    <= full_nxt;
      ovf_r                     <= ovf_nxt;
      done_r                    <= done_nxt;
      size_d_r                  <= word_size_select;
    end
  end

  // pins and status
  assign serial_clock_pin_out  = clock_polarity ^ act_r; // RQ15
  assign serial_clock_pin_oe   = active & master_mode; // RQ8
  assign serial_out_pin        = out_r;
  assign serial_out_pin_oe     = active & ~serial_out_disable & ~ss_gate; // RQ11 RQ19
  assign slave_select_pin_out  = fs_r;
  assign slave_select_pin_oe   = active & fr_out; // RQ20
  assign rx_data               = receive_holding_buffer_r;
  assign rx_full               = full_r;
  assign receive_overflow_flag = ovf_r;
  assign port1_done_flag       = done_r;
  assign done_irq              = done_r & port1_done_irq_enable; // RQ2

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  done_sets_a: assert property (clk_en && done |=> done_r) // RQ2
    else $error("done flag not set");
  rx_move_a: assert property (clk_en && done && !full_r |=> full_r && rx_data == $past(rx_word)) // RQ3
    else $error("word not moved");
  ovf_keep_a: assert property (clk_en && done && full_r && !rx_rd
    |=> ovf_r && $stable(rx_data)) // RQ4
    else $error("overflow not handled");
  ovf_freeze_a: assert property (clk_en && ovf_r && !soft_rst |=> $stable(bit_cnt_r)) // RQ5
    else $error("bits counted in overflow");
  ss_release_a: assert property (ss_gate |-> !serial_out_pin_oe) // RQ11
    else $error("output driven while deselected");
  ss_reset_a: assert property (clk_en && ss_gate |=> bit_cnt_r == 5'h0 && !loaded_r) // RQ12
    else $error("select rise did not reset");
  sck_idle_a: assert property (ms_r == SMSP_IDLE && !act_r
    |-> serial_clock_pin_out == clock_polarity) // RQ15
    else $error("clock not at idle level");
  master_go_a: assert property (clk_en && load && master_mode |=> ms_r == SMSP_RUN) // RQ9
    else $error("master did not start");
  sleep_abort_a: assert property (clk_en && cpu_sleep |=> bit_cnt_r == 5'h0 && ms_r == SMSP_IDLE) // RQ22
    else $error("sleep did not abort");
  size_reset_a: assert property (clk_en && size_chg |=> bit_cnt_r == 5'h0) // RQ17
    else $error("size change did not reset");
  sck_dir_a: assert property (!master_mode |-> !serial_clock_pin_oe) // RQ8
    else $error("slave drives clock");

  // output pins, frame pin direction and frame gating
  sdo_disable_a: assert property (serial_out_disable |-> !serial_out_pin_oe) // RQ19
    else $error("output driven while disabled");
  frame_in_a: assert property (fr_in |-> !slave_select_pin_oe) // RQ20
    else $error("frame pin driven as input");
  frame_out_a: assert property (active && fr_out |-> slave_select_pin_oe) // RQ20
    else $error("frame pin not driven as output");
  frame_gate_a: assert property (clk_en && framed_mode_enable && !armed_r && !soft_rst
    |=> $stable(bit_cnt_r)) // RQ21
    else $error("bits counted before frame pulse");

  // overflow flag keeps and clears
  ovf_sticky_a: assert property (clk_en && ovf_r && !ovf_clear |=> ovf_r) // RQ24
    else $error("overflow flag lost");
  ovf_clear_a: assert property (clk_en && ovf_clear && !(done && full_r && !rx_rd)
    |=> !ovf_r) // RQ24
    else $error("overflow flag not cleared");

  // shifter load, shift and output bit
  tx_reload_a: assert property (clk_en && load && !samp
    |=> serial_shift_reg_r == $past(transmit_holding_buffer_r) && loaded_r) // RQ6
    else $error("holding word not loaded");
  shift_in_a: assert property (clk_en && samp
    |=> serial_shift_reg_r == {$past(serial_shift_reg_r[14:0]), $past(sdi_s)}) // RQ1
    else $error("input bit not shifted in");
  out_msb_a: assert property (clk_en && chg && !load
    |=> serial_out_pin == $past(smsp_msb(serial_shift_reg_r, word_size_select))) // RQ18
    else $error("output bit not from msb");
  done_count_a: assert property (clk_en && done |=> bit_cnt_r == 5'h0) // RQ1
    else $error("bit counter not cleared");

  // master clock and completion timing
  half_hold_a: assert property (clk_en && master_mode && !soft_rst && !gen_edge
    |=> act_r == $past(act_r)) // RQ13
    else $error("clock phase changed early");
  master_mid_a: assert property (clk_en && master_mode && clock_edge_select && done
    |=> ms_r == SMSP_LAST) // RQ10
    else $error("master done not mid bit");
  slave_latch_a: assert property (clk_en && !master_mode && done |=> port1_done_flag) // RQ10
    else $error("slave done not on latch");
  idle_halt_a: assert property (clk_en && cpu_idle && stop_in_idle
    |=> ms_r == SMSP_IDLE && bit_cnt_r == 5'h0) // RQ23
    else $error("idle did not halt");
  size_word_a: assert property (clk_en && done && !full_r && !word_size_select
    |=> rx_data[15:8] == 8'h00) // RQ16
    else $error("byte word not zero extended");

  master_word_c: cover property (master_mode && done && !full_r);
  slave_word_c: cover property (!master_mode && done && word_size_select);
  overflow_c: cover property (done && full_r && !rx_rd);
  framed_c: cover property (framed_mode_enable && done);
  sleep_abort_c: cover property (cpu_sleep && bit_cnt_r != 5'h0);
endmodule : smsp_port

// ===== smsp_slave_model.sv
module smsp_slave_model (
  input  wire logic        sck,   // clock from master
  input  wire logic        cpol,  // idle clock level
  input  wire logic        cke,   // 1 samples on lead edge
  input  wire logic        wide,  // 16-bit words
  input  wire logic        load,  // preset reply word
  input  wire logic [15:0] reply, // word to send
  input  wire logic        mosi,  // data from master
  output logic             miso,  // data to master
  output logic      [15:0] got    // shift content
);
  timeunit 1ns;
  timeprecision 1ns;
  logic samp = 1'b0; // bit caught on sample edge
  logic act;
  initial got = 16'h0;
  assign act  = sck ^ cpol;
  assign miso = wide ? got[15] : got[7];
  // preset, or sample and shift on opposite edges; received bits echo next word
  always @(posedge act or negedge act or posedge load) begin
    if (load) begin
      got <= reply;
    end else if (act == cke) begin
      samp <= mosi;
    end else begin
      got <= {got[14:0], samp};
    end
  end
endmodule : smsp_slave_model

// ===== smsp_port_test.sv
module smsp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, port_enable = 1'b1, master_mode = 1'b1;
  logic word_size_select = 1'b0, clock_polarity = 1'b0, clock_edge_select = 1'b1;
  logic serial_out_disable = 1'b0, framed_mode_enable = 1'b0, frame_sync_direction = 1'b0;
  logic slave_select_enable = 1'b0, stop_in_idle = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0;
  logic [1:0] primary_prescale = 2'h2;
  logic [2:0] secondary_prescale = 3'h6;
  logic tx_valid = 1'b0, rx_rd = 1'b0, ovf_clear = 1'b0, done_clear = 1'b0, load = 1'b0;
  logic port1_done_irq_enable = 1'b1, serial_clock_pin_in = 1'b0, slave_select_pin_in = 1'b1;
  logic [15:0] tx_data = 16'h0, reply = 16'h0, rx_data, got;
  logic tx_ready, rx_full, receive_overflow_flag, port1_done_flag, done_irq;
  logic serial_clock_pin_out, serial_clock_pin_oe, serial_in_pin, serial_out_pin;
  logic serial_out_pin_oe, slave_select_pin_out, slave_select_pin_oe;
  int num_errors = 0, checks_done = 0, cyc = 0, act_n = 0;

  // 10 MHz system clock
  always #50 clk = ~clk;

  smsp_port u_dut (
    .clk, .reset_n, .clk_en, .port_enable, .master_mode, .word_size_select,
    .clock_polarity, .clock_edge_select, .serial_out_disable, .framed_mode_enable,
    .frame_sync_direction, .slave_select_enable, .primary_prescale, .secondary_prescale,
    .stop_in_idle, .cpu_idle, .cpu_sleep, .tx_valid, .tx_ready, .tx_data, .rx_rd,
    .rx_data, .rx_full, .receive_overflow_flag, .ovf_clear, .port1_done_flag, .done_clear,
    .port1_done_irq_enable, .done_irq, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe, .serial_in_pin, .serial_out_pin, .serial_out_pin_oe,
    .slave_select_pin_in, .slave_select_pin_out, .slave_select_pin_oe
  );

  smsp_slave_model u_far (
    .sck(serial_clock_pin_out), .cpol(clock_polarity), .cke(clock_edge_select),
    .wide(word_size_select), .load, .reply, .mosi(serial_out_pin), .miso(serial_in_pin), .got
  );

  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one-cycle strobe on the named control, raised and dropped at rising edges
  task automatic pulse(input string nm);
    case (nm)
      "load":      load <= 1'b1;
      "rx_rd":     rx_rd <= 1'b1;
      "ovf_clear": ovf_clear <= 1'b1;
      default:     done_clear <= 1'b1;
    endcase
    @(posedge clk);
    case (nm)
      "load":      load <= 1'b0;
      "rx_rd":     rx_rd <= 1'b0;
      "ovf_clear": ovf_clear <= 1'b0;
      default:     done_clear <= 1'b0;
    endcase
  endtask : pulse

  task automatic preset(input logic [15:0] w);
    reply <= w;
    pulse("load");
  endtask : preset

  task automatic wr(input logic [15:0] w);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data  <= w;
    @(posedge clk);
    tx_valid <= 1'b0;
    chk("tx_ready", 16'h1, tx_ready);
  endtask : wr

  // wait for the done flag or a new overflow, counting active clock cycles
  task automatic run(input int lim);
    logic o0;
    o0 = receive_overflow_flag;
    act_n = 0;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      if (serial_clock_pin_out !== clock_polarity) act_n++;
      if (port1_done_flag === 1'b1 || (receive_overflow_flag === 1'b1 && !o0)) break;
    end
    repeat (40) begin
      @(posedge clk);
      if (serial_clock_pin_out !== clock_polarity) act_n++;
    end
  endtask : run

  task automatic t_idle();
    tick(1);
    chk("rx_full", 16'h0, rx_full);
    chk("ovf", 16'h0, receive_overflow_flag);
    chk("done", 16'h0, port1_done_flag);
    chk("sck_oe", 16'h1, serial_clock_pin_oe);
    clock_polarity     <= 1'b1;
    serial_out_disable <= 1'b1;
    tick(2);
    chk("sck_idle", 16'h1, serial_clock_pin_out);
    chk("sdo_oe", 16'h0, serial_out_pin_oe);
    clock_polarity     <= 1'b0;
    serial_out_disable <= 1'b0;
    tick(2);
    chk("sdo_oe", 16'h1, serial_out_pin_oe);
  endtask : t_idle

  task automatic t_byte();
    preset(16'h003c);
    wr(16'h00a5);
    run(1000);
    chk("act_cycles", 16'h80, act_n[15:0]);
    chk("rx_data", 16'h003c, rx_data);
    chk("far_got", 16'h00a5, {8'h0, got[7:0]});
    chk("irq", 16'h1, done_irq);
    port1_done_irq_enable <= 1'b0;
    tick(1);
    chk("irq_off", 16'h0, done_irq);
    port1_done_irq_enable <= 1'b1;
    pulse("done_clear");
  endtask : t_byte

  task automatic t_ovf();
    wr(16'h0011);
    run(1000);
    chk("ovf", 16'h1, receive_overflow_flag);
    chk("rx_kept", 16'h003c, rx_data);
    pulse("done_clear");
    wr(16'h0022);
    run(200);
    chk("stall", 16'h0, act_n[15:0]);
    pulse("rx_rd");
    run(100);
    chk("rx_full", 16'h0, rx_full);
    chk("stall_read", 16'h0, act_n[15:0]);
    pulse("ovf_clear");
    run(1000);
    chk("ovf_clr", 16'h0, receive_overflow_flag);
    chk("rx_data", 16'h0011, rx_data);
    chk("far_got", 16'h0022, {8'h0, got[7:0]});
    pulse("rx_rd");
    pulse("done_clear");
  endtask : t_ovf

  task automatic t_word16();
    port_enable <= 1'b0;
    tick(1);
    word_size_select <= 1'b1;
    primary_prescale <= 2'h3;
    tick(1);
    port_enable <= 1'b1;
    preset(16'hbeef);
    wr(16'h1234);
    wr(16'h5678);
    run(1000);
    chk("rx_data", 16'hbeef, rx_data);
    pulse("rx_rd");
    pulse("done_clear");
    run(1000);
    chk("rx_data2", 16'h1234, rx_data);
    chk("far_got", 16'h5678, got);
    pulse("rx_rd");
    pulse("done_clear");
  endtask : t_word16

  // sleep, then stop in idle, each halting a word in flight
  task automatic t_halt();
    for (int k = 0; k < 2; k++) begin
      wr(16'h4321);
      tick(20);
      if (k == 0) begin
        cpu_sleep <= 1'b1;
      end else begin
        stop_in_idle <= 1'b1;
        cpu_idle     <= 1'b1;
      end
      tick(300);
      chk("halt_done", 16'h0, port1_done_flag);
      chk("halt_sck", 16'h0, serial_clock_pin_out);
      chk("halt_rx", 16'h1234, rx_data);
      cpu_sleep    <= 1'b0;
      stop_in_idle <= 1'b0;
      cpu_idle     <= 1'b0;
      tick(300);
      pulse("done_clear");
    end
  endtask : t_halt

  task automatic t_slave();
    master_mode         <= 1'b0;
    slave_select_enable <= 1'b1;
    tick(5);
    chk("sck_oe", 16'h0, serial_clock_pin_oe);
    chk("sdo_oe_hi", 16'h0, serial_out_pin_oe);
    slave_select_pin_in <= 1'b0;
    tick(5);
    chk("sdo_oe_lo", 16'h1, serial_out_pin_oe);
  endtask : t_slave

  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    tick(2);
    reset_n <= 1'b1;
    t_idle();
    t_byte();
    t_ovf();
    t_word16();
    t_halt();
    t_slave();
    results();
  end
endmodule : smsp_port_test
